// ===== logic/i2c_target_port.sv
// Operation
// - The block answers as a target only, at one of two bus addresses chosen by a select input.
// - It supports block writes and block reads of several consecutive register bytes per transaction.
// - The first two bytes after a write address form the 16-bit starting register address.
// - Registers are stepped in ascending order, one byte each, shifted most significant bit first.
// - A transfer may end after any complete byte and the block accepts it.
// - Acknowledged write bytes, up to FIFO_DEPTH per transaction, are buffered, committed after STOP and dropped at a repeated START; further bytes are NACKed.
`include "i2c_port_consts.svh"

// ----------------------------------------------------------------
// Write buffer FIFO
// ----------------------------------------------------------------
module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // Depth must be a power of two for the wrap bit compare
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
      $error("word_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      rd_reg;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   // Honest full and empty from pointer compare
   assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid = (wr_reg != rd_reg);
   assign out_data  = mem_reg[rd_reg[AW-1:0]];
   // Pointers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else if (flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
      end
   end
   // Storage
   always_ff @(posedge core_clk) begin
      if (push) mem_reg[wr_reg[AW-1:0]] <= in_data;
   end
endmodule // word_fifo

// ----------------------------------------------------------------
// I2C target with commit-on-STOP
// ----------------------------------------------------------------
module i2c_target_port
   import i2c_port_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                   core_clk,
   input  wire logic                   rstn,
   input  wire logic                   addr_sel,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe,
   output i2c_port_pkg::reg_word_t     wr_word,
   output logic                        wr_valid,
   input  wire logic                   wr_ready,
   output logic [15:0]                 rd_addr,
   input  wire logic [7:0]             rd_data,
   output logic                        busy
);
   import i2c_port_pkg::*;
   // Buffer needs at least two words
   if (FIFO_DEPTH < 2) begin : g_depth_chk
      $error("FIFO_DEPTH too small");
   end

   // Pin synchronisers
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   end

   // Edge and condition decode
   wire scl      = scl_sync_reg[1];
   wire sda      = sda_sync_reg[1];
   wire scl_rise = scl && !scl_d_reg;
   wire scl_fall = !scl && scl_d_reg;
   wire start_c  = scl && scl_d_reg && sda_d_reg && !sda;
   wire stop_c   = scl && scl_d_reg && !sda_d_reg && sda;

   i2c_state_t  state_reg;
   logic [7:0]  shift_reg;
   logic [3:0]  bitcnt_reg;
   logic [1:0]  abytes_reg;
   logic [15:0] ptr_reg;
   logic        rw_reg;
   logic        match_reg;
   logic        nack_reg;
   logic        commit_reg;
   logic        drive_reg;
   logic        drive_val_reg;

   wire [6:0] own_addr  = addr_sel ? `ADDR_SEL1 : `ADDR_SEL0;
   wire       addr_hit  = (shift_reg[7:1] == own_addr);
   wire       byte_done = (bitcnt_reg == `BYTE_BITS);
   wire       is_addr   = (abytes_reg != `REG_ADDR_BYTES);

   // Buffer between the link and the register file
   reg_word_t fifo_in;
   reg_word_t fifo_out;
   logic      fifo_in_ready;
   logic      fifo_out_valid;
   // Each acknowledged data byte of a block is queued
   wire       fifo_push = (state_reg == ST_WACK) && scl_rise && !is_addr && !nack_reg;
   assign fifo_in.addr = ptr_reg;
   assign fifo_in.data = shift_reg;
   wire fifo_drain = commit_reg && (!wr_valid || wr_ready);
   // Discard buffered bytes on a new START unless the commit window is open
   wire fifo_flush = start_c && !commit_reg;
   word_fifo #(.WIDTH($bits(reg_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk (core_clk),
      .rstn     (rstn),
      .flush    (fifo_flush),
      .in_valid (fifo_push),
      .in_ready (fifo_in_ready),
      .in_data  (fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_drain),
      .out_data (fifo_out)
   );

   // Protocol state machine
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= ST_IDLE;
         shift_reg  <= `ZERO_BYTE;
         bitcnt_reg <= 4'h0;
         abytes_reg <= 2'h0;
         ptr_reg    <= `ZERO_ADDR;
         rw_reg     <= 1'b0;
         match_reg  <= 1'b0;
         nack_reg   <= 1'b0;
      end else if (start_c) begin
         state_reg  <= ST_ADDR;
         bitcnt_reg <= 4'h0;
         match_reg  <= 1'b0;
      end else if (stop_c) begin
         // Early end accepted at any point
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               bitcnt_reg <= 4'h0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_reg  <= {shift_reg[6:0], sda};
                  bitcnt_reg <= bitcnt_reg + 4'h1;
               end else if (scl_fall && byte_done) begin
                  if (addr_hit) begin
                     state_reg  <= ST_AACK;
                     rw_reg     <= shift_reg[0];
                     match_reg  <= 1'b1;
                     // Write address restarts register address capture
                     if (!shift_reg[0]) abytes_reg <= 2'h0;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  bitcnt_reg <= 4'h0;
                  state_reg  <= rw_reg ? ST_RBYTE : ST_WBYTE;
                  if (rw_reg) shift_reg <= rd_data;
               end
            end
            ST_WBYTE: begin
               if (scl_rise) begin
                  shift_reg  <= {shift_reg[6:0], sda};
                  bitcnt_reg <= bitcnt_reg + 4'h1;
               end else if (scl_fall && byte_done) begin
                  state_reg <= ST_WACK;
                  nack_reg  <= !is_addr && !fifo_in_ready;
               end
            end
            ST_WACK: begin
               if (scl_rise) begin
                  // Two address bytes, high byte first
                  if (is_addr) begin
                     ptr_reg    <= {ptr_reg[7:0], shift_reg};
                     abytes_reg <= abytes_reg + 2'h1;
                  end else if (!nack_reg) begin
                     ptr_reg <= ptr_reg + 16'h0001;
                  end
               end else if (scl_fall) begin
                  bitcnt_reg <= 4'h0;
                  state_reg  <= ST_WBYTE;
               end
            end
            ST_RBYTE: begin
               if (scl_fall) begin
                  shift_reg  <= {shift_reg[6:0], 1'b0};
                  bitcnt_reg <= bitcnt_reg + 4'h1;
                  if (bitcnt_reg == {1'b0, `LAST_BIT}) begin
                     state_reg <= ST_RACK;
                     ptr_reg   <= ptr_reg + 16'h0001;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_reg <= sda;
               end else if (scl_fall) begin
                  bitcnt_reg <= 4'h0;
                  shift_reg  <= rd_data;
                  state_reg  <= nack_reg ? ST_IDLE : ST_RBYTE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // SDA drive: low for ACK, data zeros while reading
   wire drv_ack  = (state_reg == ST_AACK) || ((state_reg == ST_WACK) && !nack_reg);
   wire drv_data = (state_reg == ST_RBYTE) && !shift_reg[7];
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         drive_reg     <= 1'b0;
         drive_val_reg <= 1'b1;
      end else begin
         drive_reg     <= drv_ack || drv_data;
         drive_val_reg <= 1'b0;
      end
   end
   assign sda_oe  = drive_reg;
   assign sda_out = drive_val_reg;

   // Commit window opens at STOP and closes when drained
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         commit_reg <= 1'b0;
      end else if (stop_c && match_reg && !rw_reg) begin
         commit_reg <= 1'b1;
      end else if (!fifo_out_valid && (!wr_valid || wr_ready)) begin
         // Close only once the last word has been taken
         commit_reg <= 1'b0;
      end
   end

   // Register-file write port and read address
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_valid <= 1'b0;
         wr_word  <= '0;
         rd_addr  <= `ZERO_ADDR;
         busy     <= 1'b0;
      end else begin
         if (fifo_drain) begin
            wr_valid <= fifo_out_valid;
            wr_word  <= fifo_out;
         end
         rd_addr <= ptr_reg;
         busy    <= (state_reg != ST_IDLE) || commit_reg || wr_valid;
      end
   end
endmodule // i2c_target_port

// ===== logic/i2c_port_consts.svh
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH
// Bus address choices, 7-bit form of the write-address bytes
`define ADDR_SEL0      7'h68
`define ADDR_SEL1      7'h6A
// Bits in a byte and bytes in the register address
`define BYTE_BITS      4'h8
`define LAST_BIT       3'h7
`define REG_ADDR_BYTES 2'h2
`define ZERO_BYTE      8'h00
`define ZERO_ADDR      16'h0000
`endif

// ===== logic/i2c_port_pkg.sv
package i2c_port_pkg;
   // Register access presented to the register file
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
   } reg_word_t;
   // Protocol states
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_ADDR  = 7'b0000010,
      ST_AACK  = 7'b0000100,
      ST_WBYTE = 7'b0001000,
      ST_WACK  = 7'b0010000,
      ST_RBYTE = 7'b0100000,
      ST_RACK  = 7'b1000000
   } i2c_state_t;
endpackage

// ===== sim/i2c_ctrl_model.sv
// -----
// Bus controller model, open drain
// -----
module i2c_ctrl_model (
   input  wire logic core_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      pull
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus: both lines released
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // Wait n core cycles, five make half a link period
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic start();
      cyc(2);
      pull = 1'b0;
      cyc(3);
      scl = 1'b1;
      cyc(5);
      pull = 1'b1;
      cyc(5);
      scl = 1'b0;
   endtask
   task automatic stop();
      cyc(2);
      pull = 1'b1;
      cyc(3);
      scl = 1'b1;
      cyc(5);
      pull = 1'b0;
      cyc(5);
   endtask
   // Data moves only while the clock is low
   task automatic bit_xfer(input logic b, output logic r);
      cyc(2);
      pull = !b;
      cyc(3);
      scl = 1'b1;
      cyc(5);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = !r;
   endtask
   // ACK each byte, NACK the last
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
      bit_xfer(last, r);
   endtask
endmodule // i2c_ctrl_model

// ===== sim/i2c_target_port_assertions.sv
module i2c_target_port_assertions
   import i2c_port_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        addr_sel,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire reg_word_t   wr_word,
   input wire logic        wr_valid,
   input wire logic        wr_ready,
   input wire logic [15:0] rd_addr,
   input wire logic [7:0]  rd_data,
   input wire logic        busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_take;
      wr_valid && wr_ready;
   endsequence
   a_valid_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
      else $error("commit word changed before accept");
   a_commit_stop: assert property ($rose(wr_valid) |-> scl_in && sda_in)
      else $error("commit began before stop");
   a_addr_ascend: assert property (s_take ##1 s_take |-> wr_word.addr == $past(wr_word.addr) + 16'h0001)
      else $error("commit addresses not ascending");
   a_quiet_idle: assert property (!busy |-> !sda_oe)
      else $error("data line pulled while idle");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line changed while clock high");
   a_bit_stands: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("driven bit too short");
   a_commit_busy: assert property (wr_valid |-> busy)
      else $error("commit while not busy");
   a_open_drain: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   a_drain_done: assert property ($fell(busy) |-> !wr_valid)
      else $error("idle with words pending");
endmodule // i2c_target_port_assertions

// ===== sim/clock_gen_i2c_register_port_tb_top.sv
`include "i2c_port_consts.svh"
module clock_gen_i2c_register_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import i2c_port_pkg::*;
   logic        core_clk, rstn, addr_sel, wr_ready, wr_valid, sda_oe, sda_out, busy, scl, pull;
   reg_word_t   wr_word;
   logic [15:0] rd_addr, last_addr;
   logic [7:0]  mem [256];
   int          miscompares, checks_done;
   wire         sda = !(sda_oe || pull);
   // Register file read port
   wire  [7:0]  rd_data = mem[rd_addr[7:0]];
   i2c_target_port #(.FIFO_DEPTH(8)) dut_u (.core_clk(core_clk), .rstn(rstn), .addr_sel(addr_sel),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wr_word(wr_word),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
   i2c_ctrl_model m_u (.core_clk(core_clk), .sda(sda), .scl(scl), .pull(pull));
   // Register file write port
   always @(posedge core_clk) if (wr_valid && wr_ready) begin
      mem[wr_word.addr[7:0]] <= wr_word.data;
      last_addr <= wr_word.addr;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 500 && busy !== 1'b0; n++) @(negedge core_clk);
      chk(16'(busy), 16'h0000);
   endtask
   task automatic hdr(input logic [6:0] dev, input logic [15:0] ra);
      logic a0, a1, a2;
      m_u.start();
      m_u.wbyte({dev, 1'b0}, a0);
      m_u.wbyte(ra[15:8], a1);
      m_u.wbyte(ra[7:0], a2);
      chk(16'({a0, a1, a2}), 16'h0007);
   endtask
   // -----
   // Scenarios
   // -----
   task automatic t_addr();
      logic a;
      for (int s = 0; s < 2; s++) begin
         addr_sel = s[0];
         m_u.start();
         m_u.wbyte({`ADDR_SEL0, 1'b0}, a);
         m_u.stop();
         chk(16'(a), 16'(s == 0));
         m_u.start();
         m_u.wbyte({`ADDR_SEL1, 1'b0}, a);
         m_u.stop();
         chk(16'(a), 16'(s == 1));
      end
      addr_sel = 1'b0;
      $display("test addr done");
   endtask
   task automatic t_write();
      logic a;
      hdr(`ADDR_SEL0, 16'h0010);
      for (int i = 0; i < 9; i++) begin
         m_u.wbyte(8'hA0 + 8'(i), a);
         chk(16'(a), 16'(i < 8));
      end
      chk(16'(mem[8'h10]), 16'h004A);
      wr_ready = 1'b0;
      m_u.stop();
      m_u.cyc(20);
      chk(16'(wr_valid), 16'h0001);
      wr_ready = 1'b1;
      wait_idle();
      for (int i = 0; i < 9; i++) chk(16'(mem[8'h10 + 8'(i)]), 16'(i < 8 ? 8'hA0 + 8'(i) : 8'h42));
      $display("test write done");
   endtask
   task automatic t_read();
      logic       a;
      logic [7:0] d;
      hdr(`ADDR_SEL0, 16'h0012);
      m_u.start();
      m_u.wbyte({`ADDR_SEL0, 1'b1}, a);
      chk(16'(a), 16'h0001);
      for (int i = 0; i < 4; i++) begin
         m_u.rbyte(i == 3, d);
         chk(16'(d), 16'(8'hA2 + 8'(i)));
      end
      m_u.stop();
      wait_idle();
      $display("test read done");
   endtask
   task automatic t_short();
      logic a;
      addr_sel = 1'b1;
      hdr(`ADDR_SEL1, 16'h01FF);
      m_u.wbyte(8'h3C, a);
      m_u.stop();
      wait_idle();
      chk(16'(mem[8'hFF]), 16'h003C);
      chk(last_addr, 16'h01FF);
      $display("test short done");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Clock, 8 ns period
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Main sequence
   initial begin
      rstn = 1'b0;
      addr_sel = 1'b0;
      wr_ready = 1'b1;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
      repeat (20) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) @(negedge core_clk);
      t_addr();
      t_write();
      t_read();
      t_short();
      finish_test();
   end
   // Watchdog
   initial begin
      #400000;
      miscompares++;
      finish_test();
   end
endmodule // clock_gen_i2c_register_port_tb_top
bind i2c_target_port i2c_target_port_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.core_clk(core_clk),
   .rstn(rstn), .addr_sel(addr_sel), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data),
   .busy(busy));
